// ---- atcb_pkg.sv ----
// Summary of operation
// - Counter holds still while the working period reload value is zero.
// - Period reload register is 16 bits, resets to all ones, feeds working reload.
// - Repetition down-counter issues an update at zero, then restarts from repetition value.
// - Repetition down-counter reloads only at its update event.
// - One update every repetition value plus one periods or half periods.
// - Compare write goes active at once without preload, else at update.
// - Four active compare values are compared to the counter and drive outputs.
// - Input channels latch the counter on capture; software writes are ignored.
// - Active break clears main output enable at once, without a clock edge.
// - Auto enable lets an update set main output enable when break is inactive.
// - Main output enable low forces outputs off or idle; high follows enable bits.
// - Break polarity selects active low (0) or active high (1) break input.
// - Break enable gates both break input and clock security failure.
// - Break polarity and enable writes act one clock after the write.
// - Protection level one or more blocks auto enable, polarity and enable writes.
// - Protection level accepts one write after reset, then stays frozen.
// - Level one blocks dead-time and break bits; level two adds off-state selects.
// - Dead-time field picks step of one, two, eight or sixteen clocks and offset.
package atcb_pkg;
  localparam int ADDR_W = 8;
  localparam int CH_N = 4;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_ARR = 8'h2C;
  localparam logic [7:0] OFF_RCR = 8'h30;
  localparam logic [7:0] OFF_CCR [0:3] = '{8'h34, 8'h38, 8'h3C, 8'h40};
  localparam logic [7:0] OFF_BREAK_DEADTIME_CONTROL = 8'h44;
  localparam logic [15:0] ARR_RST = 16'hFFFF;
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam int CTRL_UG_BIT = 2;
  localparam int CTRL_W = 20;
  localparam logic [1:0] LOCK_L1 = 2'h1;
  localparam logic [1:0] LOCK_L2 = 2'h2;
  localparam int DT_SH_B = 1;
  localparam int DT_SH_C = 3;
  localparam int DT_SH_D = 4;
  localparam int DT_W_MIN = 10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] ccne;
    logic [3:0] cce;
    logic [3:0] in_mode;
    logic [3:0] pe;
    logic [1:0] pad;
    logic center;
    logic en;
  } atcb_ctrl_s;

  typedef struct packed {
    logic main_output_enable;
    logic automatic_output_enable;
    logic break_polarity;
    logic break_enable;
    logic run_off_state_select;
    logic idle_off_state_select;
    logic [1:0] lock;
    logic [7:0] dtg;
  } atcb_break_deadtime_control_s;

  typedef struct packed {
    logic data;
    logic en;
  } atcb_pin_s;
endpackage

// ---- atcb_deadtime.sv ----
`timescale 1ns/1ps
module atcb_deadtime #(
  parameter int DT_W = 10
) (
  input logic ref_clk_in, // Clock
  input logic rst_n_in, // Sync reset
  input logic ref_in, // Reference waveform
  input logic [7:0] dtg_in, // Dead-time field
  output logic oc_out, // Main phase
  output logic ocn_out // Complementary phase
);
  import atcb_pkg::*;
  logic [DT_W-1:0] dt_len;
  logic [DT_W-1:0] dt_cnt;
  logic ref_q;

  if (DT_W < DT_W_MIN)
  begin : g_chk
    $error("DT_W too narrow for dead-time range");
  end

  always_comb
  begin
    if (!dtg_in[7])
      dt_len = DT_W'(dtg_in[6:0]);
    else if (!dtg_in[6])
      dt_len = DT_W'({1'b1, dtg_in[5:0]}) << DT_SH_B;
    else if (!dtg_in[5])
      dt_len = DT_W'({1'b1, dtg_in[4:0]}) << DT_SH_C;
    else
      dt_len = DT_W'({1'b1, dtg_in[4:0]}) << DT_SH_D;
  end

  // Both phases low for the dead time after every reference edge
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      ref_q <= 1'b0;
      dt_cnt <= '0;
      oc_out <= 1'b0;
      ocn_out <= 1'b0;
    end
    else
    begin
      ref_q <= ref_in;
      if (ref_in != ref_q)
      begin
        dt_cnt <= dt_len;
        oc_out <= (dt_len == '0) & ref_in;
        ocn_out <= (dt_len == '0) & ~ref_in;
      end
      else if (dt_cnt != '0)
        dt_cnt <= dt_cnt - 1'b1;
      else
      begin
        oc_out <= ref_q;
        ocn_out <= ~ref_q;
      end
    end
  end
endmodule

// ---- atcb_top.sv ----
`timescale 1ns/1ps
module atcb_top #(
  parameter int AW = atcb_pkg::ADDR_W
) (
  input logic ref_clk_in, // 25 MHz clock
  input logic rst_n_in, // Sync reset, active low
  input logic [AW-1:0] s_axi_awaddr_in, // Write address
  input logic s_axi_awvalid_in, // Write address valid
  output logic s_axi_awready_out, // Write address ready
  input logic [31:0] s_axi_wdata_in, // Write data
  input logic [3:0] s_axi_wstrb_in, // Byte strobes
  input logic s_axi_wvalid_in, // Write data valid
  output logic s_axi_wready_out, // Write data ready
  output logic [1:0] s_axi_bresp_out, // Write response
  output logic s_axi_bvalid_out, // Write response valid
  input logic s_axi_bready_in, // Write response ready
  input logic [AW-1:0] s_axi_araddr_in, // Read address
  input logic s_axi_arvalid_in, // Read address valid
  output logic s_axi_arready_out, // Read address ready
  output logic [31:0] s_axi_rdata_out, // Read data
  output logic [1:0] s_axi_rresp_out, // Read response
  output logic s_axi_rvalid_out, // Read valid
  input logic s_axi_rready_in, // Read ready
  input logic break_input_in, // Break pin
  input logic clock_security_failure_in, // Clock failure event
  input logic [3:0] channel_capture_input_in, // Capture pins
  output logic [15:0] counter_value_out, // Running counter
  output logic update_event_out, // Update pulse
  output logic [3:0] channel_compare_output_out, // Compare results
  output atcb_pkg::atcb_pin_s [3:0] channel_out_out, // Main outputs
  output atcb_pkg::atcb_pin_s [3:0] complementary_out_out // Complementary outputs
);
  import atcb_pkg::*;

  if (AW < ADDR_W)
  begin : g_chk
    $error("AW too narrow for register map");
  end

  logic aw_full;
  logic w_full;
  logic [AW-1:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic [31:0] wmask;
  logic wr_fire;
  logic wr_hit;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_arr;
  logic sel_rcr;
  logic sel_break_deadtime_control;
  logic [3:0] sel_ccr;
  logic [31:0] rd_mux;
  logic rd_hit;
  atcb_ctrl_s ctrl;
  atcb_ctrl_s next_ctrl;
  atcb_break_deadtime_control_s break_deadtime_control;
  atcb_break_deadtime_control_s bw;
  logic break_deadtime_control_written;
  logic [15:0] period_reload_value;
  logic [15:0] arr_act;
  logic [15:0] repetition_count_value;
  logic [15:0] cnt;
  logic [7:0] repetition_value;
  logic dir;
  logic run;
  logic pev;
  logic upd;
  logic ug;
  logic [15:0] ccr [CH_N];
  logic [15:0] ccr_act [CH_N];
  logic [15:0] ccr_eff [CH_N];
  logic [31:0] ccr_w [CH_N];
  logic [31:0] w_ctrl;
  logic [31:0] w_arr;
  logic [31:0] w_rcr;
  logic [31:0] w_break_deadtime_control;
  logic [3:0] ref_q;
  logic [3:0] dt_oc;
  logic [3:0] dt_ocn;
  logic [3:0] cap_s1;
  logic [3:0] cap_s2;
  logic [3:0] cap_s3;
  logic [3:0] cap_edge;
  logic brk_s1;
  logic brk_s2;
  logic bkp_q;
  logic bke_q;
  logic brk_now;
  logic brk_sync;
  logic moe_eff;
  atcb_pin_s [3:0] oc_q;
  atcb_pin_s [3:0] ocn_q;

  function automatic logic [31:0] mrg(input logic [31:0] old, input logic [31:0] m,
                                      input logic [31:0] d);
    return (old & ~m) | (d & m);
  endfunction

  // Register bus slave
  assign wmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  assign wr_fire = aw_full & w_full & ~s_axi_bvalid_out;
  assign s_axi_awready_out = ~aw_full;
  assign s_axi_wready_out = ~w_full;
  assign s_axi_arready_out = ~s_axi_rvalid_out;
  assign sel_ctrl = (wa == AW'(OFF_CTRL));
  assign sel_stat = (wa == AW'(OFF_STAT));
  assign sel_arr = (wa == AW'(OFF_ARR));
  assign sel_rcr = (wa == AW'(OFF_RCR));
  assign sel_break_deadtime_control = (wa == AW'(OFF_BREAK_DEADTIME_CONTROL));
  assign wr_hit = sel_ctrl | sel_stat | sel_arr | sel_rcr | sel_break_deadtime_control | (|sel_ccr);

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      wa <= '0;
      wd <= 32'h0;
      ws <= 4'h0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && !aw_full)
      begin
        aw_full <= 1'b1;
        wa <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_full)
      begin
        w_full <= 1'b1;
        wd <= s_axi_wdata_in;
        ws <= s_axi_wstrb_in;
      end
      if (wr_fire)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready_in)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  always_comb
  begin
    rd_hit = 1'b1;
    rd_mux = 32'h0;
    if (s_axi_araddr_in == AW'(OFF_CTRL))
      rd_mux = {12'h0, ctrl};
    else if (s_axi_araddr_in == AW'(OFF_STAT))
      rd_mux = {cnt, repetition_value, 5'h0, dir, brk_now, moe_eff};
    else if (s_axi_araddr_in == AW'(OFF_ARR))
      rd_mux = {16'h0, period_reload_value};
    else if (s_axi_araddr_in == AW'(OFF_RCR))
      rd_mux = {16'h0, repetition_count_value};
    else if (s_axi_araddr_in == AW'(OFF_BREAK_DEADTIME_CONTROL))
      rd_mux = {16'h0, break_deadtime_control};
    else
      rd_hit = 1'b0;
    for (int i = 0; i < CH_N; i++)
    begin
      if (s_axi_araddr_in == AW'(OFF_CCR[i]))
      begin
        rd_mux = {16'h0, ccr[i]};
        rd_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= RESP_OKAY;
    end
    else if (s_axi_arvalid_in && !s_axi_rvalid_out)
    begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_mux;
      s_axi_rresp_out <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready_in)
      s_axi_rvalid_out <= 1'b0;
  end

  // Control, period and repetition registers
  assign w_ctrl = mrg({12'h0, ctrl}, wmask, wd);
  assign w_arr = mrg({16'h0, period_reload_value}, wmask, wd);
  assign w_rcr = mrg({16'h0, repetition_count_value}, wmask, wd);
  assign w_break_deadtime_control = mrg({16'h0, break_deadtime_control}, wmask, wd);
  assign bw = atcb_break_deadtime_control_s'(w_break_deadtime_control[15:0]);
  assign ug = wr_fire & sel_ctrl & w_ctrl[CTRL_UG_BIT];

  always_comb
  begin
    next_ctrl = atcb_ctrl_s'(w_ctrl[CTRL_W-1:0]);
    next_ctrl.pad = 2'h0;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      ctrl <= '0;
      period_reload_value <= ARR_RST;
      repetition_count_value <= REG16_RST;
    end
    else if (wr_fire)
    begin
      if (sel_ctrl)
        ctrl <= next_ctrl;
      if (sel_arr)
        period_reload_value <= w_arr[15:0];
      if (sel_rcr)
        repetition_count_value <= {8'h00, w_rcr[7:0]};
    end
  end

  // Counter and repetition pacing
  assign run = ctrl.en && (arr_act != 16'h0);
  assign pev = run && ((ctrl.center && dir) ? (cnt == 16'h0) : (cnt >= arr_act));
  assign upd = ug | (pev && (repetition_value == 8'h00));

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt <= 16'h0;
      dir <= 1'b0;
    end
    else if (ug)
    begin
      cnt <= 16'h0;
      dir <= 1'b0;
    end
    else if (run)
    begin
      if (!ctrl.center)
        cnt <= pev ? 16'h0 : cnt + 16'h1;
      else if (pev)
      begin
        dir <= ~dir;
        cnt <= dir ? cnt + 16'h1 : cnt - 16'h1;
      end
      else
        cnt <= dir ? cnt - 16'h1 : cnt + 16'h1;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      repetition_value <= 8'h00;
      arr_act <= ARR_RST;
    end
    else if (upd)
    begin
      repetition_value <= repetition_count_value[7:0];
      arr_act <= period_reload_value;
    end
    else if (pev)
      repetition_value <= repetition_value - 8'h01;
  end

  // Break detection, raw path for immediate disable
  assign brk_now = bke_q & (clock_security_failure_in | ~(break_input_in ^ bkp_q));
  assign brk_sync = bke_q & (clock_security_failure_in | ~(brk_s2 ^ bkp_q));
  assign moe_eff = break_deadtime_control.main_output_enable & ~brk_now;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      brk_s1 <= 1'b0;
      brk_s2 <= 1'b0;
      bkp_q <= 1'b0;
      bke_q <= 1'b0;
    end
    else
    begin
      brk_s1 <= break_input_in;
      brk_s2 <= brk_s1;
      bkp_q <= break_deadtime_control.break_polarity;
      bke_q <= break_deadtime_control.break_enable;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      break_deadtime_control <= '0;
      break_deadtime_control_written <= 1'b0;
    end
    else
    begin
      if (wr_fire && sel_break_deadtime_control)
      begin
        break_deadtime_control_written <= 1'b1;
        if (!break_deadtime_control_written)
          break_deadtime_control.lock <= bw.lock;
        if (break_deadtime_control.lock < LOCK_L1)
        begin
          break_deadtime_control.dtg <= bw.dtg;
          break_deadtime_control.automatic_output_enable <= bw.automatic_output_enable;
          break_deadtime_control.break_polarity <= bw.break_polarity;
          break_deadtime_control.break_enable <= bw.break_enable;
        end
        if (break_deadtime_control.lock < LOCK_L2)
        begin
          break_deadtime_control.run_off_state_select <= bw.run_off_state_select;
          break_deadtime_control.idle_off_state_select <= bw.idle_off_state_select;
        end
      end
      if (brk_sync)
        break_deadtime_control.main_output_enable <= 1'b0;
      else
        break_deadtime_control.main_output_enable <= ((wr_fire && sel_break_deadtime_control) ? bw.main_output_enable : break_deadtime_control.main_output_enable) | (upd & break_deadtime_control.automatic_output_enable);
    end
  end

  // Capture input synchronisers
  assign cap_edge = cap_s2 & ~cap_s3;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      cap_s1 <= 4'h0;
      cap_s2 <= 4'h0;
      cap_s3 <= 4'h0;
    end
    else
    begin
      cap_s1 <= channel_capture_input_in;
      cap_s2 <= cap_s1;
      cap_s3 <= cap_s2;
    end
  end

  // Per-channel compare, capture and output stage
  for (genvar i = 0; i < CH_N; i++)
  begin : g_ch
    atcb_pin_s next_oc;
    atcb_pin_s next_ocn;

    assign sel_ccr[i] = (wa == AW'(OFF_CCR[i]));
    assign ccr_w[i] = mrg({16'h0, ccr[i]}, wmask, wd);
    assign ccr_eff[i] = ctrl.pe[i] ? ccr_act[i] : ccr[i];

    always_ff @(posedge ref_clk_in)
    begin
      if (!rst_n_in)
        ccr[i] <= REG16_RST;
      else if (ctrl.in_mode[i])
      begin
        if (cap_edge[i] && ctrl.cce[i])
          ccr[i] <= cnt;
      end
      else if (wr_fire && sel_ccr[i])
        ccr[i] <= ccr_w[i][15:0];
    end

    always_ff @(posedge ref_clk_in)
    begin
      if (!rst_n_in)
        ccr_act[i] <= REG16_RST;
      else if (upd)
        ccr_act[i] <= ccr[i];
    end

    always_ff @(posedge ref_clk_in)
    begin
      if (!rst_n_in)
        ref_q[i] <= 1'b0;
      else
        ref_q[i] <= ~ctrl.in_mode[i] && (cnt < ccr_eff[i]);
    end

    atcb_deadtime u_dt (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .ref_in(ref_q[i]),
      .dtg_in(break_deadtime_control.dtg),
      .oc_out(dt_oc[i]),
      .ocn_out(dt_ocn[i])
    );

    always_comb
    begin
      next_oc = '0;
      next_ocn = '0;
      if (ctrl.in_mode[i])
      begin
        next_oc = '0;
        next_ocn = '0;
      end
      else if (moe_eff)
      begin
        next_oc.en = ctrl.cce[i] | (break_deadtime_control.run_off_state_select & ctrl.ccne[i]);
        next_ocn.en = ctrl.ccne[i] | (break_deadtime_control.run_off_state_select & ctrl.cce[i]);
        next_oc.data = ctrl.cce[i] & (ctrl.ccne[i] ? dt_oc[i] : ref_q[i]);
        next_ocn.data = ctrl.ccne[i] & (ctrl.cce[i] ? dt_ocn[i] : ref_q[i]);
      end
      else
      begin
        next_oc.en = break_deadtime_control.idle_off_state_select & (ctrl.cce[i] | ctrl.ccne[i]);
        next_ocn.en = break_deadtime_control.idle_off_state_select & (ctrl.cce[i] | ctrl.ccne[i]);
      end
    end

    always_ff @(posedge ref_clk_in)
    begin
      if (!rst_n_in)
      begin
        oc_q[i] <= '0;
        ocn_q[i] <= '0;
      end
      else
      begin
        oc_q[i] <= next_oc;
        ocn_q[i] <= next_ocn;
      end
    end

    assign channel_out_out[i].data = oc_q[i].data & ~brk_now;
    assign complementary_out_out[i].data = ocn_q[i].data & ~brk_now;
    assign channel_out_out[i].en = brk_now ? next_oc.en : oc_q[i].en;
    assign complementary_out_out[i].en = brk_now ? next_ocn.en : ocn_q[i].en;

    a_ccr_direct: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (wr_fire && sel_ccr[i] && !ctrl.pe[i] && !ctrl.in_mode[i])
      |=> ccr_eff[i] == $past(ccr_w[i][15:0]))
      else $error("compare value not applied at once");
    a_ccr_input_ro: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      (ctrl.in_mode[i] && !cap_edge[i]) |=> $stable(ccr[i]))
      else $error("input channel compare changed without capture");
  end

  assign counter_value_out = cnt;
  assign update_event_out = upd;
  assign channel_compare_output_out = ref_q;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_upd;
    upd;
  endsequence

  sequence s_break_deadtime_control_locked_wr;
    wr_fire && sel_break_deadtime_control && (break_deadtime_control.lock != 2'h0);
  endsequence

  a_cnt_blocked: assert property ((arr_act == 16'h0 && !ug) |=> $stable(cnt))
    else $error("counter moved with zero period");
  a_arr_transfer: assert property (s_upd |=> arr_act == $past(period_reload_value))
    else $error("working reload not loaded at update");
  a_rep_reload: assert property (s_upd |=> repetition_value == $past(repetition_count_value[7:0]))
    else $error("repetition counter not reloaded");
  a_rep_hold: assert property ((!upd && !pev) |=> $stable(repetition_value))
    else $error("repetition counter changed outside events");
  a_rep_pace: assert property ((pev && repetition_value != 8'h00 && !ug) |->
    !upd ##1 repetition_value == $past(repetition_value) - 8'h01)
    else $error("repetition pacing wrong");
  a_break_kill: assert property (brk_now |-> (channel_out_out[0].data == 1'b0)
    && (complementary_out_out[3].data == 1'b0) && !moe_eff)
    else $error("outputs active during break");
  a_aoe_set: assert property ((upd && break_deadtime_control.automatic_output_enable && !brk_sync) |=> break_deadtime_control.main_output_enable)
    else $error("auto enable did not set main enable");
  a_idle_force: assert property (!moe_eff |=> (channel_out_out[1].data == 1'b0)
    && (complementary_out_out[1].data == 1'b0))
    else $error("outputs not idle with main enable low");
  a_break_gate: assert property (!bke_q |-> !brk_now)
    else $error("break acted while disabled");
  a_bkp_delay: assert property ($rose(break_deadtime_control.break_polarity) |-> !bkp_q ##1 bkp_q)
    else $error("break polarity delay wrong");
  a_lock_block: assert property (s_break_deadtime_control_locked_wr |=> $stable(break_deadtime_control.break_polarity)
    && $stable(break_deadtime_control.break_enable) && $stable(break_deadtime_control.automatic_output_enable) && $stable(break_deadtime_control.dtg))
    else $error("locked break bits changed");
  a_lock_once: assert property (break_deadtime_control_written |=> $stable(break_deadtime_control.lock))
    else $error("protection level changed twice");
endmodule

// ---- atcb_far_end.sv ----
`timescale 1ns/1ps
module atcb_far_end (
  input wire logic ref_clk_in, // Clock
  output logic break_out, // Break pin level
  output logic csf_out, // Clock failure event
  output logic [3:0] capture_out // Capture pins
);
  initial
  begin
    break_out = 1'b0;
    csf_out = 1'b0;
    capture_out = 4'h0;
  end

  // Level changes land just after an edge
  task automatic drive(input logic break_input, input logic csf);
    @(posedge ref_clk_in);
    break_out <= break_input;
    csf_out <= csf;
  endtask

  // Held long enough to pass the input synchroniser
  task automatic capture(input int ch);
    @(posedge ref_clk_in);
    capture_out[ch] <= 1'b1;
    repeat (4) @(posedge ref_clk_in);
    capture_out[ch] <= 1'b0;
  endtask
endmodule

// ---- tb_advanced_timer_compare_break.sv ----
`timescale 1ns/1ps
module tb_advanced_timer_compare_break;
  import atcb_pkg::*;
  localparam int REPV = 2;
  localparam int ARRV = 3;
  logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, break_input, csf, upd;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [3:0] cap, cmp;
  logic [15:0] cnt, v;
  atcb_pin_s [3:0] ch_o, cp_o;
  int failures, compares, cyc, t0, t1, t2, t3;

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  atcb_top i_dut (
    .ref_clk_in(clk), .rst_n_in(rst_n),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awrdy),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arrdy), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .break_input_in(break_input),
    .clock_security_failure_in(csf), .channel_capture_input_in(cap),
    .counter_value_out(cnt), .update_event_out(upd), .channel_compare_output_out(cmp),
    .channel_out_out(ch_o), .complementary_out_out(cp_o)
  );

  atcb_far_end i_far (.ref_clk_in(clk), .break_out(break_input), .csf_out(csf), .capture_out(cap));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (awvalid && awrdy) awvalid <= 1'b0;
      if (wvalid && wrdy) wvalid <= 1'b0;
      if (bvalid)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge clk);
      if (arvalid && arrdy) arvalid <= 1'b0;
      if (rvalid)
      begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(nm, e, rd);
    chk("rresp", RESP_OKAY, rs);
  endtask

  task automatic next_upd(output int t);
    do
      @(posedge clk);
    while (upd !== 1'b1);
    t = cyc;
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    print_verdict();
  end

  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    do_reset();
    rchk("arr_rst", OFF_ARR, 32'h0000FFFF);
    rchk("rcr_rst", OFF_RCR, 32'h0);
    for (int i = 0; i < CH_N; i++) rchk("ccr_rst", OFF_CCR[i], 32'h0);
    rchk("break_deadtime_control_rst", OFF_BREAK_DEADTIME_CONTROL, 32'h0);
    rdr(8'h48);
    chk("rd_unmapped", RESP_SLVERR, rs);
    wr(8'h48, 32'h1);
    chk("wr_unmapped", RESP_SLVERR, rs);
    wr(OFF_RCR, 32'hFFFF);
    rchk("rcr_width", OFF_RCR, 32'h00FF);
    // Edge-aligned repetition pacing
    wr(OFF_ARR, ARRV);
    wr(OFF_RCR, REPV);
    wr(OFF_CTRL, 32'h5);
    next_upd(t3);
    next_upd(t0);
    next_upd(t1);
    chk("edge_gap", (REPV + 1) * (ARRV + 1), t1 - t0);
    wr(OFF_RCR, 32'h0);
    next_upd(t2);
    chk("rcr_late", (REPV + 1) * (ARRV + 1), t2 - t1);
    next_upd(t3);
    chk("rcr_new", ARRV + 1, t3 - t2);
    // Center-aligned: half periods
    wr(OFF_RCR, REPV);
    wr(OFF_CTRL, 32'h7);
    next_upd(t0);
    next_upd(t1);
    next_upd(t2);
    chk("center_gap", (REPV + 1) * ARRV, t2 - t1);
    // Zero period blocks the counter
    wr(OFF_ARR, 32'h0);
    wr(OFF_CTRL, 32'h5);
    repeat (8) @(posedge clk);
    chk("cnt_blocked", 32'h0, cnt);
    wr(OFF_ARR, 32'h5);
    wr(OFF_CTRL, 32'h5);
    repeat (3) @(posedge clk);
    chk("cnt_runs", 32'h1, cnt != 16'h0);
    // Input channel three
    wr(OFF_ARR, 32'hFFFF);
    wr(OFF_CTRL, 32'h4405);
    wr(OFF_CCR[2], 32'h1234);
    rchk("ccr_ro", OFF_CCR[2], 32'h0);
    wr(OFF_CTRL, 32'h4400);
    @(posedge clk);
    v = cnt;
    chk("cnt_moved", 32'h1, v != 16'h0);
    i_far.capture(2);
    repeat (4) @(posedge clk);
    rchk("ccr_capture", OFF_CCR[2], {16'h0, v});
    // Preload on channel two only, counter held at zero
    wr(OFF_CTRL, 32'h24);
    wr(OFF_CCR[0], 32'h5);
    wr(OFF_CCR[1], 32'h5);
    repeat (3) @(posedge clk);
    chk("cmp_direct", 32'h1, {cmp[3], cmp[1:0]});
    wr(OFF_CTRL, 32'h24);
    repeat (3) @(posedge clk);
    chk("cmp_preload", 32'h3, {cmp[3], cmp[1:0]});
    // Break handling, channel one output enabled
    wr(OFF_CTRL, 32'h1000);
    wr(OFF_BREAK_DEADTIME_CONTROL, 32'hF000);
    repeat (3) @(posedge clk);
    chk("out_on", 32'hC, {ch_o[0], cp_o[0]});
    i_far.drive(1'b1, 1'b0);
    #1;
    chk("brk_async", 32'h0, ch_o[0].data);
    repeat (5) @(posedge clk);
    rchk("moe_clr", OFF_BREAK_DEADTIME_CONTROL, 32'h7000);
    i_far.drive(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk("out_idle", 32'h0, ch_o[0]);
    wr(OFF_CTRL, 32'h1004);
    rchk("moe_auto", OFF_BREAK_DEADTIME_CONTROL, 32'hF000);
    wr(OFF_BREAK_DEADTIME_CONTROL, 32'hD000);
    repeat (5) @(posedge clk);
    rchk("brk_low", OFF_BREAK_DEADTIME_CONTROL, 32'h5000);
    i_far.drive(1'b1, 1'b0);
    wr(OFF_BREAK_DEADTIME_CONTROL, 32'hE000);
    i_far.drive(1'b1, 1'b1);
    repeat (5) @(posedge clk);
    rchk("brk_off", OFF_BREAK_DEADTIME_CONTROL, 32'hE000);
    i_far.drive(1'b0, 1'b1);
    wr(OFF_BREAK_DEADTIME_CONTROL, 32'hF000);
    repeat (5) @(posedge clk);
    rchk("csf_brk", OFF_BREAK_DEADTIME_CONTROL, 32'h7000);
    i_far.drive(1'b0, 1'b0);
    // Protection level one after a fresh reset
    do_reset();
    wr(OFF_BREAK_DEADTIME_CONTROL, 32'h0155);
    wr(OFF_BREAK_DEADTIME_CONTROL, 32'hFEAA);
    rchk("lock_hold", OFF_BREAK_DEADTIME_CONTROL, 32'h8D55);
    // Dead-time on channel one with both phases enabled, 85 clocks
    wr(OFF_CTRL, 32'h11000);
    wr(OFF_CCR[0], 32'h5);
    repeat (10) @(posedge clk);
    chk("dt_gap", 32'h0, {ch_o[0].data, cp_o[0].data});
    repeat (90) @(posedge clk);
    chk("dt_on", 32'h2, {ch_o[0].data, cp_o[0].data});
    print_verdict();
  end
endmodule
